/* rtl/pssps_pkg.sv */
package pssps_pkg;
   // Register offsets
   localparam logic [7:0] SKEW_OFS       = 8'h55;
   localparam logic [7:0] STRAP_ONE_OFS  = 8'h6e;
   localparam logic [7:0] STRAP_TWO_OFS  = 8'h6f;
   localparam logic [7:0] BYTE_TOT_OFS   = 8'h71;
   localparam logic [7:0] ERR_OVF_OFS    = 8'h72;
   localparam logic [7:0] IRQ_STAT_OFS   = 8'h78;
   localparam logic [7:0] IRQ_EN_OFS     = 8'h79;
   localparam logic [7:0] IRQ_CLR_OFS    = 8'h7a;
   localparam logic [7:0] CHK_MODE_OFS   = 8'h7e;
   // Field positions
   localparam int SKEW_B_LSB   = 4;
   localparam int MIRROR_BIT   = 15;
   localparam int DSHIFT_BIT   = 14;
   localparam int REFOFF_BIT   = 13;
   localparam int PAROFF_BIT   = 12;
   localparam int SERON_BIT    = 11;
   localparam int AXOFF_BIT    = 10;
   localparam int FXOVER_BIT   = 9;
   localparam int HDUP_BIT     = 8;
   localparam int NEGOFF_BIT   = 7;
   localparam int NEGSEL_BIT   = 5;
   localparam int QDROP_BIT    = 10;
   localparam int TXSKEW_LSB   = 4;
   localparam int PKT_OVF_BIT  = 10;
   localparam int BYTE_OVF_BIT = 9;
   localparam int LOCK_BIT     = 0;
   localparam int LOCKCLR_BIT  = 1;
   // Interrupt status bits
   localparam int IRQ_BYTE_OVF = 0;
   localparam int IRQ_PKT_OVF  = 1;
   localparam int IRQ_ERR_OVF  = 2;
   localparam int IRQ_W        = 3;
   localparam logic [15:0] RESET_WORD = 16'h0000;
endpackage : pssps_pkg

/* rtl/pssps_wrap_counter.sv */
`timescale 1ns/10ps
module pssps_wrap_counter #(
   parameter int W = 8
) (
   input  wire logic         clk,
   input  wire logic         arst_n,
   input  wire logic         clr,
   input  wire logic         inc,
   input  wire logic         saturate,
   output logic [W-1:0]      count_q,
   output logic              wrap
);
   // Wraps only when not saturating
   assign wrap = inc && !clr && !saturate && (&count_q);

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         count_q <= '0;
      end else if (clr) begin
         count_q <= '0;
      end else if (inc && !(saturate && (&count_q))) begin
         count_q <= count_q + 1'b1;
      end
   end
endmodule : pssps_wrap_counter

/* rtl/pssps_status_bank.sv */
`timescale 1ns/10ps
// How it works
// R1 - Skew register: lane B 7:4, A 3:0
// R2 - Bits 15,14,13: mirror, downshift, refout off
// R3 - Bit 12 parallel off, 11 serial on
// R4 - Bit 10 crossover off, 9 forced crossed
// R5 - Bit 8 half duplex, 7 negotiation off
// R6 - Bit 5 select, 3:0 address, 6,4 zero
// R7 - Register two bit 10 quick drop
// R8 - Register two 6:4 transmit delay strap
// R9 - Register two 2:0 receive delay, 3 zero
// R10 - Sixteen-bit byte total, resets zero
// R11 - Byte total saturates when mode zero
// R12 - Eight-bit bad byte total, saturating likewise
// R13 - Write bit 0 locks counter snapshot
// R14 - Write bit 1 clears counters, snapshots and wrap flags
// R15 - Packet wrap flag sticky until clear
// R16 - Byte wrap flag sticky until clear
// R17 - Unassigned bits of checker register zero
// R18 - Nonzero mode wraps and sets flag
// R19 - Straps captured at reset release, held
module pssps_status_bank
   import pssps_pkg::*;
#(
   parameter int BYTE_W = 16,
   parameter int ERR_W  = 8
) (
   input  wire logic        clk,
   input  wire logic        arst_n,
   input  wire logic [7:0]  addr,
   input  wire logic [15:0] wdata,
   input  wire logic        wr,
   input  wire logic        rd,
   output logic [15:0]      rdata,
   input  wire logic [3:0]  first_lane_align_offset,
   input  wire logic [3:0]  second_lane_align_offset,
   input  wire logic        strap_mirror,
   input  wire logic        strap_downshift,
   input  wire logic        strap_refout_off,
   input  wire logic        strap_parallel_mac_off,
   input  wire logic        strap_serial_mac_on,
   input  wire logic        strap_auto_crossover_off,
   input  wire logic        strap_forced_crossover,
   input  wire logic        strap_half_duplex,
   input  wire logic        strap_negotiation_off,
   input  wire logic        strap_negotiation_select,
   input  wire logic [3:0]  strap_mgmt_address,
   input  wire logic        strap_quick_drop,
   input  wire logic [2:0]  strap_tx_delay,
   input  wire logic [2:0]  strap_rx_delay,
   input  wire logic        chk_byte_valid,
   input  wire logic        chk_byte_bad,
   input  wire logic        chk_packet_wrap,
   output logic             irq
);
   //////////////////////////////////////////////////////////////////////////
   // Skew sampling, one register per lane
   logic [3:0] first_lane_q;
   logic [3:0] second_lane_q;

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         first_lane_q <= '0;
      end else begin
         first_lane_q <= first_lane_align_offset;         // see R1
      end
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         second_lane_q <= '0;
      end else begin
         second_lane_q <= second_lane_align_offset;       // see R1
      end
   end

   //////////////////////////////////////////////////////////////////////////
   // Strap capture on the first edge after reset release
   logic        strap_done_q;
   logic        latched_mirror_q;
   logic        latched_downshift_q;
   logic        latched_refout_off_q;
   logic        latched_parallel_mac_off_q;
   logic        latched_serial_mac_on_q;
   logic        latched_auto_crossover_off_q;
   logic        latched_forced_crossover_q;
   logic        latched_half_duplex_q;
   logic        latched_negotiation_off_q;
   logic        latched_negotiation_select_q;
   logic [3:0]  latched_mgmt_address_q;
   logic        latched_quick_drop_q;
   logic [2:0]  latched_tx_delay_q;
   logic [2:0]  latched_rx_delay_q;
   logic [15:0] strap_one_word;
   logic [15:0] strap_two_word;

   // Pins keep moving after capture; only a new reset picks them up
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         strap_done_q <= 1'b0;
      end else begin
         strap_done_q <= 1'b1;                            // see R19
      end
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         latched_mirror_q             <= 1'b0;
         latched_downshift_q          <= 1'b0;
         latched_refout_off_q         <= 1'b0;
         latched_parallel_mac_off_q   <= 1'b0;
         latched_serial_mac_on_q      <= 1'b0;
         latched_auto_crossover_off_q <= 1'b0;
         latched_forced_crossover_q   <= 1'b0;
         latched_half_duplex_q        <= 1'b0;
         latched_negotiation_off_q    <= 1'b0;
         latched_negotiation_select_q <= 1'b0;
         latched_mgmt_address_q       <= 4'h0;
      end else if (!strap_done_q) begin
         latched_mirror_q             <= strap_mirror;             // see R19
         latched_downshift_q          <= strap_downshift;
         latched_refout_off_q         <= strap_refout_off;
         latched_parallel_mac_off_q   <= strap_parallel_mac_off;
         latched_serial_mac_on_q      <= strap_serial_mac_on;
         latched_auto_crossover_off_q <= strap_auto_crossover_off;
         latched_forced_crossover_q   <= strap_forced_crossover;
         latched_half_duplex_q        <= strap_half_duplex;
         latched_negotiation_off_q    <= strap_negotiation_off;
         latched_negotiation_select_q <= strap_negotiation_select;
         latched_mgmt_address_q       <= strap_mgmt_address;
      end
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         latched_quick_drop_q <= 1'b0;
         latched_tx_delay_q   <= 3'h0;
         latched_rx_delay_q   <= 3'h0;
      end else if (!strap_done_q) begin
         latched_quick_drop_q <= strap_quick_drop;        // see R19
         latched_tx_delay_q   <= strap_tx_delay;
         latched_rx_delay_q   <= strap_rx_delay;
      end
   end

   always_comb begin
      strap_one_word               = RESET_WORD;
      strap_one_word[MIRROR_BIT]   = latched_mirror_q;             // see R2
      strap_one_word[DSHIFT_BIT]   = latched_downshift_q;          // see R2
      strap_one_word[REFOFF_BIT]   = latched_refout_off_q;         // see R2
      strap_one_word[PAROFF_BIT]   = latched_parallel_mac_off_q;   // see R3
      strap_one_word[SERON_BIT]    = latched_serial_mac_on_q;      // see R3
      strap_one_word[AXOFF_BIT]    = latched_auto_crossover_off_q; // see R4
      strap_one_word[FXOVER_BIT]   = latched_forced_crossover_q;   // see R4
      strap_one_word[HDUP_BIT]     = latched_half_duplex_q;        // see R5
      strap_one_word[NEGOFF_BIT]   = latched_negotiation_off_q;    // see R5
      strap_one_word[NEGSEL_BIT]   = latched_negotiation_select_q; // see R6
      strap_one_word[3:0]          = latched_mgmt_address_q;       // see R6
      strap_two_word               = RESET_WORD;
      strap_two_word[QDROP_BIT]    = latched_quick_drop_q;         // see R7
      strap_two_word[TXSKEW_LSB +: 3] = latched_tx_delay_q;        // see R8
      strap_two_word[2:0]          = latched_rx_delay_q;           // see R9
   end

   //////////////////////////////////////////////////////////////////////////
   // Register write strobes
   logic wr_chk;
   logic wr_mode;
   logic wr_irq_en;
   logic wr_irq_clr;

   assign wr_chk     = wr && (addr == ERR_OVF_OFS);
   assign wr_mode    = wr && (addr == CHK_MODE_OFS);
   assign wr_irq_en  = wr && (addr == IRQ_EN_OFS);
   assign wr_irq_clr = wr && (addr == IRQ_CLR_OFS);

   //////////////////////////////////////////////////////////////////////////
   // Checker counters
   logic              mode_q;
   logic              lock_pulse;
   logic              clear_pulse;
   logic              saturate;
   logic [BYTE_W-1:0] byte_cnt;
   logic [ERR_W-1:0]  err_cnt;
   logic              byte_wrap;
   logic              err_wrap;

   assign saturate    = (mode_q == 1'b0);                 // see R11
   assign lock_pulse  = wr_chk && wdata[LOCK_BIT];        // see R13
   assign clear_pulse = wr_chk && wdata[LOCKCLR_BIT];     // see R14

   pssps_wrap_counter #(.W(BYTE_W)) u_byte_cnt (
      .clk      (clk),
      .arst_n   (arst_n),
      .clr      (clear_pulse),
      .inc      (chk_byte_valid),
      .saturate (saturate),
      .count_q  (byte_cnt),
      .wrap     (byte_wrap)
   );                                                     // see R10

   pssps_wrap_counter #(.W(ERR_W)) u_err_cnt (
      .clk      (clk),
      .arst_n   (arst_n),
      .clr      (clear_pulse),
      .inc      (chk_byte_valid && chk_byte_bad),
      .saturate (saturate),
      .count_q  (err_cnt),
      .wrap     (err_wrap)
   );                                                     // see R12

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         mode_q <= 1'b0;
      end else if (wr_mode) begin
         mode_q <= wdata[0];
      end
   end

   //////////////////////////////////////////////////////////////////////////
   // Snapshot taken on lock; clear zeroes it
   logic [BYTE_W-1:0] byte_snap_q;
   logic [ERR_W-1:0]  err_snap_q;

   // Live counters are seen by software only through this copy
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         byte_snap_q <= '0;
      end else if (clear_pulse) begin
         byte_snap_q <= '0;                               // see R14
      end else if (lock_pulse) begin
         byte_snap_q <= byte_cnt;                         // see R13
      end
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         err_snap_q <= '0;
      end else if (clear_pulse) begin
         err_snap_q <= '0;                                // see R14
      end else if (lock_pulse) begin
         err_snap_q <= err_cnt;                           // see R13
      end
   end

   //////////////////////////////////////////////////////////////////////////
   // Wrap flags: a packet wrap beats clear in the same cycle; clear suppresses a byte wrap
   logic pkt_ovf_q;
   logic byte_ovf_q;

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         pkt_ovf_q <= 1'b0;
      end else if (chk_packet_wrap) begin
         pkt_ovf_q <= 1'b1;                               // see R15
      end else if (clear_pulse) begin
         pkt_ovf_q <= 1'b0;
      end
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         byte_ovf_q <= 1'b0;
      end else if (byte_wrap) begin
         byte_ovf_q <= 1'b1;                              // see R16 R18
      end else if (clear_pulse) begin
         byte_ovf_q <= 1'b0;
      end
   end

   //////////////////////////////////////////////////////////////////////////
   // Interrupt status, enable, clear
   logic [IRQ_W-1:0] irq_stat_q;
   logic [IRQ_W-1:0] irq_en_q;
   logic [IRQ_W-1:0] irq_evt;
   logic [IRQ_W-1:0] irq_clr;

   always_comb begin
      irq_evt               = '0;
      irq_evt[IRQ_BYTE_OVF] = byte_wrap;
      irq_evt[IRQ_PKT_OVF]  = chk_packet_wrap;
      irq_evt[IRQ_ERR_OVF]  = err_wrap;                   // see R18
   end

   always_comb begin
      irq_clr = '0;
      if (wr_irq_clr) begin
         irq_clr = wdata[IRQ_W-1:0];
      end
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         irq_stat_q <= '0;
      end else begin
         irq_stat_q <= (irq_stat_q & ~irq_clr) | irq_evt;
      end
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         irq_en_q <= '0;
      end else if (wr_irq_en) begin
         irq_en_q <= wdata[IRQ_W-1:0];
      end
   end

   assign irq = |(irq_stat_q & irq_en_q);

   //////////////////////////////////////////////////////////////////////////
   // Read port, data one cycle after strobe
   logic [15:0] rd_d;

   always_comb begin
      rd_d = RESET_WORD;
      if (addr == SKEW_OFS) begin
         rd_d[SKEW_B_LSB +: 4] = second_lane_q;           // see R1
         rd_d[3:0]             = first_lane_q;            // see R1
      end else if (addr == STRAP_ONE_OFS) begin
         rd_d = strap_one_word;
      end else if (addr == STRAP_TWO_OFS) begin
         rd_d = strap_two_word;
      end else if (addr == BYTE_TOT_OFS) begin
         rd_d[BYTE_W-1:0] = byte_snap_q;                  // see R10
      end else if (addr == ERR_OVF_OFS) begin
         rd_d[ERR_W-1:0]   = err_snap_q;                  // see R17
         rd_d[PKT_OVF_BIT]  = pkt_ovf_q;
         rd_d[BYTE_OVF_BIT] = byte_ovf_q;
      end else if (addr == IRQ_STAT_OFS) begin
         rd_d[IRQ_W-1:0] = irq_stat_q;
      end else if (addr == IRQ_EN_OFS) begin
         rd_d[IRQ_W-1:0] = irq_en_q;
      end else if (addr == CHK_MODE_OFS) begin
         rd_d[0] = mode_q;
      end
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         rdata <= RESET_WORD;
      end else if (rd) begin
         rdata <= rd_d;
      end else begin
         rdata <= RESET_WORD;
      end
   end
endmodule : pssps_status_bank

/* bench/pssps_status_props.sv */
`timescale 1ns/10ps
module pssps_status_props
   import pssps_pkg::*;
#(
   parameter int BYTE_W = 16,
   parameter int ERR_W  = 8
) (
   input wire logic        clk,
   input wire logic        arst_n,
   input wire logic [7:0]  addr,
   input wire logic [15:0] wdata,
   input wire logic        wr,
   input wire logic        rd,
   input wire logic [15:0] rdata,
   input wire logic [3:0]  first_lane_align_offset,
   input wire logic [3:0]  second_lane_align_offset,
   input wire logic        irq
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!arst_n);
   idle_rdata_a: assert property (!rd |=> rdata == 16'h0000) else $error("rdata not idle");
   skew_value_a: assert property (rd && addr == SKEW_OFS && $stable(first_lane_align_offset)
      && $stable(second_lane_align_offset) |=> rdata == {8'h00,
      $past(second_lane_align_offset), $past(first_lane_align_offset)}) else $error("bad skew");
   strap_one_rsv_a: assert property (rd && addr == STRAP_ONE_OFS |=> !rdata[6] && !rdata[4])
      else $error("strap one spare bit set");
   strap_two_rsv_a: assert property (rd && addr == STRAP_TWO_OFS |=> rdata[15:11] == 5'h00
      && rdata[9:7] == 3'h0 && !rdata[3]) else $error("strap two spare bit set");
   chk_rsv_a: assert property (rd && addr == ERR_OVF_OFS |=> rdata[15:11] == 5'h00 && !rdata[8])
      else $error("checker spare bit set");
   clr_zero_a: assert property (wr && addr == ERR_OVF_OFS && wdata[1] ##1 !wr ##1
      rd && addr == BYTE_TOT_OFS |=> rdata == 16'h0000) else $error("total not cleared");
   clr_reg_rd_a: assert property (rd && addr == IRQ_CLR_OFS |=> rdata == 16'h0000)
      else $error("clear register readable");
   unmapped_rd_a: assert property (rd && addr == 8'h00 |=> rdata == 16'h0000)
      else $error("unmapped read not zero");
   cover property (rd && addr == ERR_OVF_OFS);
   cover property (irq);
   cover property (wr && addr == ERR_OVF_OFS && wdata[1]);
endmodule : pssps_status_props
////////////////////////////////////////////////////////////////////////////////
bind pssps_status_bank pssps_status_props #(.BYTE_W(BYTE_W), .ERR_W(ERR_W)) u_props (
   .clk, .arst_n, .addr, .wdata, .wr, .rd, .rdata, .first_lane_align_offset,
   .second_lane_align_offset, .irq);

/* bench/pssps_status_bank_tb.sv */
`timescale 1ns/10ps
module pssps_status_bank_tb;
   // Short counters keep saturation and wrap cheap to reach
   localparam int BW = 4;
   localparam int EW = 3;
   logic        clk    = 1'b0;
   logic        arst_n = 1'b0;
   logic [7:0]  addr   = 8'h00;
   logic [15:0] wdata  = 16'h0000;
   logic        wr     = 1'b0;
   logic        rd     = 1'b0;
   logic [15:0] rdata;
   logic [3:0]  lane_a = 4'h3;
   logic [3:0]  lane_b = 4'hc;
   logic [15:0] sv1    = 16'ha5a5;
   logic [15:0] sv2    = 16'h0455;
   logic        bval   = 1'b0;
   logic        bbad   = 1'b0;
   logic        pwrap  = 1'b0;
   logic        irq;
   int          n_fail = 0;
   int          n_compared = 0;
   logic [23:0] rows [10] = '{24'h5500c3, 24'h6ea5a5, 24'h6f0455, 24'h710000, 24'h720000,
                              24'h780000, 24'h790000, 24'h7a0000, 24'h7e0000, 24'h000000};
   pssps_status_bank #(.BYTE_W(BW), .ERR_W(EW)) uut (
      .clk, .arst_n, .addr, .wdata, .wr, .rd, .rdata,
      .first_lane_align_offset(lane_a), .second_lane_align_offset(lane_b),
      .strap_mirror(sv1[15]), .strap_downshift(sv1[14]), .strap_refout_off(sv1[13]),
      .strap_parallel_mac_off(sv1[12]), .strap_serial_mac_on(sv1[11]),
      .strap_auto_crossover_off(sv1[10]), .strap_forced_crossover(sv1[9]),
      .strap_half_duplex(sv1[8]), .strap_negotiation_off(sv1[7]),
      .strap_negotiation_select(sv1[5]), .strap_mgmt_address(sv1[3:0]),
      .strap_quick_drop(sv2[10]), .strap_tx_delay(sv2[6:4]), .strap_rx_delay(sv2[2:0]),
      .chk_byte_valid(bval), .chk_byte_bad(bbad), .chk_packet_wrap(pwrap), .irq);
   ////////////////////////////////////////////////////////////////////////////////
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      n_compared++;
      if (seen !== exp) begin
         n_fail++;
         $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask : check
   task automatic finish_test();
      if (n_fail == 0 && n_compared > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask : finish_test
   task automatic wr_reg(input logic [7:0] a, input logic [15:0] d);
      @(posedge clk);
      addr  <= a;
      wdata <= d;
      wr    <= 1'b1;
      @(posedge clk);
      wr    <= 1'b0;
      #1;
   endtask : wr_reg
   task automatic rd_chk(input logic [7:0] a, input logic [15:0] e, input logic [15:0] m = 16'hffff);
      @(posedge clk);
      addr <= a;
      rd   <= 1'b1;
      @(posedge clk);
      rd   <= 1'b0;
      #1;
      check(rdata & m, e);
   endtask : rd_chk
   task automatic feed(input int n, input logic bad);
      @(posedge clk);
      bval <= 1'b1;
      bbad <= bad;
      repeat (n) @(posedge clk);
      bval <= 1'b0;
   endtask : feed
   task automatic do_reset();
      arst_n <= 1'b0;
      repeat (8) @(posedge clk);
      arst_n <= 1'b1;
      repeat (2) @(posedge clk);
   endtask : do_reset
   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      forever #25 clk = ~clk;
   end
   initial begin
      #200000;
      n_fail++;
      finish_test();
   end
   initial begin
      do_reset();
      foreach (rows[i]) rd_chk(rows[i][23:16], rows[i][15:0]);
      feed(20, 1'b1);
      wr_reg(8'h72, 16'h0001);
      rd_chk(8'h71, 16'h000f);
      rd_chk(8'h72, 16'h0007);
      wr_reg(8'h72, 16'h0002);
      rd_chk(8'h71, 16'h0000);
      wr_reg(8'h7e, 16'h0001);
      wr_reg(8'h79, 16'h0007);
      feed(17, 1'b1);
      @(posedge clk);
      pwrap <= 1'b1;
      @(posedge clk);
      pwrap <= 1'b0;
      wr_reg(8'h72, 16'h0001);
      check({15'h0000, irq}, 16'h0001);
      rd_chk(8'h71, 16'h0001);
      rd_chk(8'h72, 16'h0601);
      rd_chk(8'h78, 16'h0007);
      wr_reg(8'h79, 16'h0000);
      check({15'h0000, irq}, 16'h0000);
      wr_reg(8'h79, 16'h0007);
      wr_reg(8'h7a, 16'h0007);
      check({15'h0000, irq}, 16'h0000);
      rd_chk(8'h78, 16'h0000);
      feed(1, 1'b0);
      wr_reg(8'h72, 16'h0001);
      feed(3, 1'b0);
      rd_chk(8'h71, 16'h0002);
      rd_chk(8'h72, 16'h0601);
      wr_reg(8'h72, 16'h0002);
      rd_chk(8'h72, 16'h0000);
      // Straps move after capture; only a new reset may pick them up
      @(posedge clk);
      lane_a <= 4'h9;
      lane_b <= 4'h6;
      sv1    <= ~sv1;
      sv2    <= ~sv2;
      wr_reg(8'h6e, 16'hffff);
      rd_chk(8'h55, 16'h0069);
      rd_chk(8'h6e, 16'ha5a5);
      @(posedge clk);
      do_reset();
      rd_chk(8'h6e, 16'h5a0a);
      rd_chk(8'h6f, 16'h0022);
      finish_test();
   end
endmodule : pssps_status_bank_tb
